// >>> srf_defs.svh
`ifndef SRF_DEFS_SVH
`define SRF_DEFS_SVH

`define SRF_CLK_HZ 25000000
`define SRF_US_PER_S 1000000
`define SRF_POWERUP_US 1000
`define SRF_SPS_1024 1024
`define SRF_SPS_256 256
`define SRF_SPS_64 64
`define SRF_SPS_8 8

`define SRF_RATE_1024 2'h0
`define SRF_RATE_256 2'h1
`define SRF_RATE_64 2'h2
`define SRF_RATE_8 2'h3

`define SRF_MODE_CONT 2'h0
`define SRF_MODE_SINGLE 2'h1
`define SRF_MODE_SLEEP 2'h2

`define SRF_OFF_CTRL 8'h00
`define SRF_OFF_FMT 8'h04
`define SRF_OFF_PIN 8'h08
`define SRF_OFF_SNAP 8'h0C
`define SRF_GRP_BUS 4'h1
`define SRF_GRP_SENSE 4'h2
`define SRF_GRP_POWER 4'h3
`define SRF_OFF_ACCLO 8'h40
`define SRF_OFF_ACCHI 8'h44
`define SRF_OFF_COUNT 8'h48

`define SRF_CTRL_W 5
`define SRF_CTRL_RESET 5'h00
`define SRF_CTRL_RATE 1:0
`define SRF_CTRL_MODE 3:2
`define SRF_CTRL_ALARM 4
`define SRF_FMT_RESET 16'h0000
`define SRF_FMT_BUS_BIP 0
`define SRF_FMT_BUS_HALF 1
`define SRF_FMT_SNS_BIP 2
`define SRF_FMT_SNS_HALF 3
`define SRF_PIN_TYPE 0
`define SRF_PIN_NO_RISE 1
`define SRF_PIN_NO_FALL 2
`define SRF_PIN_LEVEL 3
`define SRF_PIN_RISE_SEEN 4
`define SRF_PIN_FALL_SEEN 5
`define SRF_SNAP_FULL 0
`define SRF_SNAP_KEEP 1

`define SRF_RESP_OKAY 2'h0
`define SRF_RESP_SLVERR 2'h2

`endif

// >>> srf_pkg.sv
package srf_pkg;
  typedef enum logic [3:0] {
    SRF_IDLE = 4'h1,
    SRF_WAIT = 4'h2,
    SRF_CONV = 4'h4,
    SRF_REST = 4'h8
  } srf_state_e;
  typedef logic [15:0] srf_result_t;
endpackage

// >>> srf_pin_sync.sv
`timescale 1ns/1ns
module srf_pin_sync (
  input wire logic clk,
  input wire logic resetn,
  input wire logic pinIn,
  output logic level,
  output logic rise,
  output logic fall
);
  logic stage1;
  logic stage2;
  logic stage3;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign level = stage2;
  assign rise = stage2 && !stage3;
  assign fall = !stage2 && stage3;

  a_edge_level: assert property (@(posedge clk) disable iff (!resetn)
    rise |-> level && !$past(stage2))
    else $error("rise seen without a low to high change");
endmodule

// >>> srf_format.sv
`timescale 1ns/1ns
module srf_format
  import srf_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [16:0] raw,
  input wire logic bipolar,
  input wire logic half,
  output srf_result_t result
);
  always_comb begin
    if (!bipolar) begin
      result = raw[16] ? 16'h0000 : raw[15:0];
    end else if (!half) begin
      result = raw[16:1];
    end else if (!raw[16] && raw[15]) begin
      result = 16'h7FFF;
    end else if (raw[16] && !raw[15]) begin
      result = 16'h8000;
    end else begin
      result = raw[15:0];
    end
  end

  a_unip_clamp: assert property (@(posedge clk) disable iff (!resetn)
    !bipolar && raw[16] |-> result == 16'h0000)
    else $error("unsigned result not clamped at zero");
  a_half_sign: assert property (@(posedge clk) disable iff (!resetn)
    bipolar && half |-> result[15] == raw[16])
    else $error("half range result lost its sign");
endmodule

// >>> srf_monitor.sv
`timescale 1ns/1ns
`include "srf_defs.svh"
module srf_monitor
  import srf_pkg::*;
#(
  parameter int NUM_CH = 4,
  parameter int CNT_W = 22,
  parameter int POWERUP_CYC =
    (`SRF_CLK_HZ / `SRF_US_PER_S) * `SRF_POWERUP_US,
  parameter int CYC_1024 = `SRF_CLK_HZ / `SRF_SPS_1024,
  parameter int CYC_256 = `SRF_CLK_HZ / `SRF_SPS_256,
  parameter int CYC_64 = `SRF_CLK_HZ / `SRF_SPS_64,
  parameter int CYC_8 = `SRF_CLK_HZ / `SRF_SPS_8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic ratePinIn,
  output logic ratePinOut,
  output logic ratePinOe,
  input wire logic alarmCond,
  output logic [1:0] muxChannel,
  output logic convStart,
  input wire logic adcDone,
  input wire logic [16:0] adcBusRaw,
  input wire logic [16:0] adcSenseRaw
);
  if (NUM_CH < 1 || NUM_CH > 4) begin : g_bad_ch
    $error("NUM_CH must lie between 1 and 4");
  end
  if (CYC_8 >= (1 << CNT_W) || POWERUP_CYC >= (1 << CNT_W) ||
      POWERUP_CYC < 1 || CYC_1024 < 1) begin : g_bad_cnt
    $error("timing counts do not fit CNT_W");
  end

  function automatic logic [31:0] mergeStrb(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [CNT_W-1:0] periodFor(input logic [1:0] rate);
    case (rate)
      `SRF_RATE_1024: periodFor = CNT_W'(CYC_1024);
      `SRF_RATE_256: periodFor = CNT_W'(CYC_256);
      `SRF_RATE_64: periodFor = CNT_W'(CYC_64);
      default: periodFor = CNT_W'(CYC_8);
    endcase
  endfunction

  logic pinLevel;
  logic pinRise;
  logic pinFall;
  srf_pin_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .pinIn(ratePinIn),
    .level(pinLevel),
    .rise(pinRise),
    .fall(pinFall)
  );

  // bus slave state
  logic awHeld;
  logic wHeld;
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic doWrite;
  logic wrKnown;
  logic [31:0] rdNext;
  logic rdErr;

  // configuration: pending copies wait for a host snapshot
  logic [31:0] ctrlMerged;
  logic [31:0] fmtMerged;
  logic chOk;
  logic [`SRF_CTRL_W-1:0] ctrlPend;
  logic [`SRF_CTRL_W-1:0] ctrlAct;
  logic [15:0] fmtPend;
  logic [15:0] fmtAct;
  logic snapType;
  logic noRise;
  logic noFall;
  logic riseSeen;
  logic fallSeen;

  logic alarmAct;
  logic [1:0] modeAct;
  logic [1:0] effRate;
  logic hostSnap;
  logic hostFull;
  logic pinSnap;
  logic snapAny;
  logic snapFull;

  srf_state_e state;
  srf_state_e next_state;
  logic cycStart;
  logic [1:0] cycleRate;
  logic [CNT_W-1:0] periodCnt;
  logic [CNT_W-1:0] pwrCnt;
  logic lastCh;
  logic sampleTake;
  logic cycleDone;

  logic [3:0] curFmt;
  srf_result_t fmtBus;
  srf_result_t fmtSense;
  logic signed [14:0] busTop;
  logic signed [16:0] senseExt;
  logic signed [31:0] product;

  srf_result_t latestBus [NUM_CH];
  srf_result_t latestSense [NUM_CH];
  logic [31:0] latestPower [NUM_CH];
  srf_result_t doneBus [NUM_CH];
  srf_result_t doneSense [NUM_CH];
  logic [31:0] donePower [NUM_CH];
  srf_result_t readBus [NUM_CH];
  srf_result_t readSense [NUM_CH];
  logic [31:0] readPower [NUM_CH];
  logic [55:0] acc;
  logic [31:0] accCount;
  logic [55:0] readAcc;
  logic [31:0] readCount;

  assign awready = !awHeld && !bvalid;
  assign wready = !wHeld && !bvalid;
  assign arready = !rvalid;
  assign doWrite = awHeld && wHeld && !bvalid;
  assign wrKnown = wrAddr == `SRF_OFF_CTRL || wrAddr == `SRF_OFF_FMT ||
                   wrAddr == `SRF_OFF_PIN || wrAddr == `SRF_OFF_SNAP;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      wrAddr <= 8'h00;
      wrData <= 32'h00000000;
      wrStrb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `SRF_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld <= 1'b1;
        wrAddr <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld <= 1'b1;
        wrData <= wdata;
        wrStrb <= wstrb;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wrKnown ? `SRF_RESP_OKAY : `SRF_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  assign hostSnap = doWrite && wrAddr == `SRF_OFF_SNAP && wrStrb[0] &&
                    (wrData[`SRF_SNAP_FULL] || wrData[`SRF_SNAP_KEEP]);
  assign hostFull = wrData[`SRF_SNAP_FULL];
  assign pinSnap = !alarmAct && ((pinRise && !noRise) ||
                   (pinFall && !noFall));
  assign snapAny = hostSnap || pinSnap;
  assign snapFull = (hostSnap && hostFull) || (pinSnap && !snapType);

  assign ctrlMerged = mergeStrb(32'(ctrlPend), wrData, wrStrb);
  assign fmtMerged = mergeStrb(32'(fmtPend), wrData, wrStrb);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrlPend <= `SRF_CTRL_RESET;
      fmtPend <= `SRF_FMT_RESET;
    end else if (doWrite && wrAddr == `SRF_OFF_CTRL) begin
      ctrlPend <= ctrlMerged[`SRF_CTRL_W-1:0];
    end else if (doWrite && wrAddr == `SRF_OFF_FMT) begin
      fmtPend <= fmtMerged[15:0];
    end
  end

  // only the host snapshot moves pending config into use
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrlAct <= `SRF_CTRL_RESET;
      fmtAct <= `SRF_FMT_RESET;
    end else if (hostSnap) begin
      ctrlAct <= ctrlPend;
      fmtAct <= fmtPend;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      snapType <= 1'b0;
      noRise <= 1'b0;
      noFall <= 1'b0;
      riseSeen <= 1'b0;
      fallSeen <= 1'b0;
    end else begin
      if (doWrite && wrAddr == `SRF_OFF_PIN && wrStrb[0]) begin
        snapType <= wrData[`SRF_PIN_TYPE];
        noRise <= wrData[`SRF_PIN_NO_RISE];
        noFall <= wrData[`SRF_PIN_NO_FALL];
        riseSeen <= (riseSeen && !wrData[`SRF_PIN_RISE_SEEN]) || pinRise;
        fallSeen <= (fallSeen && !wrData[`SRF_PIN_FALL_SEEN]) || pinFall;
      end else begin
        riseSeen <= riseSeen || pinRise;
        fallSeen <= fallSeen || pinFall;
      end
    end
  end

  assign alarmAct = ctrlAct[`SRF_CTRL_ALARM];
  assign modeAct = ctrlAct[`SRF_CTRL_MODE];
  // pin rate control only while the pin is not the alarm output
  assign effRate = (pinLevel && !alarmAct) ? `SRF_RATE_8
                   : ctrlAct[`SRF_CTRL_RATE];
  assign lastCh = muxChannel == 2'(NUM_CH - 1);
  assign sampleTake = state == SRF_CONV && adcDone;

  always_comb begin
    next_state = state;
    cycStart = 1'b0;
    case (state)
      SRF_IDLE: begin
        if (modeAct == `SRF_MODE_CONT) begin
          next_state = SRF_CONV;
          cycStart = 1'b1;
        end else if (modeAct == `SRF_MODE_SINGLE && pinRise &&
                     !alarmAct) begin
          next_state = SRF_WAIT;
        end
      end
      SRF_WAIT: begin
        if (modeAct == `SRF_MODE_SLEEP) begin
          next_state = SRF_IDLE;
        end else if (pwrCnt == CNT_W'(POWERUP_CYC - 1)) begin
          next_state = SRF_CONV;
          cycStart = 1'b1;
        end
      end
      SRF_CONV: begin
        if (adcDone && lastCh) begin
          next_state = SRF_REST;
        end
      end
      SRF_REST: begin
        if (periodCnt >= periodFor(cycleRate) - CNT_W'(1)) begin
          if (modeAct == `SRF_MODE_CONT) begin
            next_state = SRF_CONV;
            cycStart = 1'b1;
          end else begin
            next_state = SRF_IDLE;
          end
        end
      end
      default: next_state = SRF_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= SRF_IDLE;
      cycleRate <= `SRF_RATE_1024;
      periodCnt <= '0;
      pwrCnt <= '0;
    end else begin
      state <= next_state;
      if (cycStart) begin
        cycleRate <= effRate;
        periodCnt <= '0;
      end else if (state == SRF_CONV || state == SRF_REST) begin
        periodCnt <= periodCnt + CNT_W'(1);
      end
      pwrCnt <= (state == SRF_WAIT) ? pwrCnt + CNT_W'(1) : '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      muxChannel <= 2'h0;
      convStart <= 1'b0;
      cycleDone <= 1'b0;
    end else begin
      convStart <= cycStart || (sampleTake && !lastCh);
      cycleDone <= sampleTake && lastCh;
      if (cycStart) begin
        muxChannel <= 2'h0;
      end else if (sampleTake && !lastCh) begin
        muxChannel <= muxChannel + 2'h1;
      end
    end
  end

  assign curFmt = fmtAct[{muxChannel, 2'b00} +: 4];
  srf_format u_fmt_bus (
    .clk(clk),
    .resetn(resetn),
    .raw(adcBusRaw),
    .bipolar(curFmt[`SRF_FMT_BUS_BIP]),
    .half(curFmt[`SRF_FMT_BUS_HALF]),
    .result(fmtBus)
  );
  srf_format u_fmt_sense (
    .clk(clk),
    .resetn(resetn),
    .raw(adcSenseRaw),
    .bipolar(curFmt[`SRF_FMT_SNS_BIP]),
    .half(curFmt[`SRF_FMT_SNS_HALF]),
    .result(fmtSense)
  );

  assign busTop = {curFmt[`SRF_FMT_BUS_BIP] && fmtBus[15],
                   fmtBus[15:2]};
  assign senseExt = {curFmt[`SRF_FMT_SNS_BIP] && fmtSense[15], fmtSense};
  assign product = 32'(busTop * senseExt);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        latestBus[i] <= 16'h0000;
        latestSense[i] <= 16'h0000;
        latestPower[i] <= 32'h00000000;
        doneBus[i] <= 16'h0000;
        doneSense[i] <= 16'h0000;
        donePower[i] <= 32'h00000000;
      end
    end else begin
      if (sampleTake) begin
        latestBus[muxChannel] <= fmtBus;
        latestSense[muxChannel] <= fmtSense;
        latestPower[muxChannel] <= product;
      end
      if (cycleDone) begin
        doneBus <= latestBus;
        doneSense <= latestSense;
        donePower <= latestPower;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      acc <= 56'h00000000000000;
      accCount <= 32'h00000000;
    end else begin
      acc <= (snapFull ? 56'h00000000000000 : acc) +
             (sampleTake ? {{24{product[31]}}, product} : 56'h0);
      accCount <= (snapFull ? 32'h00000000 : accCount) +
                  (sampleTake && lastCh ? 32'h00000001 : 32'h00000000);
    end
  end

  // readable copy is taken in the snapshot cycle itself
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        readBus[i] <= 16'h0000;
        readSense[i] <= 16'h0000;
        readPower[i] <= 32'h00000000;
      end
      readAcc <= 56'h00000000000000;
      readCount <= 32'h00000000;
    end else if (snapAny) begin
      readBus <= doneBus;
      readSense <= doneSense;
      readPower <= donePower;
      readAcc <= acc;
      readCount <= accCount;
    end
  end

  // three bits so that a full set of four channels still decodes
  assign chOk = 3'(araddr[3:2]) < 3'(NUM_CH);

  always_comb begin
    rdNext = 32'h00000000;
    rdErr = 1'b0;
    if (araddr[7:4] == `SRF_GRP_BUS && chOk) begin
      rdNext = {16'h0000, readBus[araddr[3:2]]};
    end else if (araddr[7:4] == `SRF_GRP_SENSE && chOk) begin
      rdNext = {16'h0000, readSense[araddr[3:2]]};
    end else if (araddr[7:4] == `SRF_GRP_POWER && chOk) begin
      rdNext = readPower[araddr[3:2]];
    end else begin
      case (araddr)
        `SRF_OFF_CTRL: rdNext = 32'(ctrlPend);
        `SRF_OFF_FMT: rdNext = 32'(fmtPend);
        `SRF_OFF_PIN: rdNext = {26'h0, fallSeen, riseSeen,
                                pinLevel, noFall, noRise, snapType};
        `SRF_OFF_SNAP: rdNext = 32'h00000000;
        `SRF_OFF_ACCLO: rdNext = readAcc[31:0];
        `SRF_OFF_ACCHI: rdNext = {8'h00, readAcc[55:32]};
        `SRF_OFF_COUNT: rdNext = readCount;
        default: rdErr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `SRF_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rdNext;
      rresp <= rdErr ? `SRF_RESP_SLVERR : `SRF_RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // open-drain alarm: pulls low while the condition holds
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ratePinOe <= 1'b0;
    end else begin
      ratePinOe <= alarmAct && alarmCond;
    end
  end
  assign ratePinOut = 1'b0;

  a_slow_rate: assert property (@(posedge clk) disable iff (!resetn)
    cycStart && pinLevel && !alarmAct |=> cycleRate == `SRF_RATE_8)
    else $error("pin high did not select slow rate");
  a_alarm_rate: assert property (@(posedge clk) disable iff (!resetn)
    cycStart && alarmAct |=> cycleRate == $past(ctrlAct[1:0]))
    else $error("alarm role did not use programmed rate");
  a_rate_hold: assert property (@(posedge clk) disable iff (!resetn)
    !cycStart && state != SRF_IDLE |=> $stable(cycleRate))
    else $error("rate changed inside a cycle");
  a_power_wait: assert property (@(posedge clk) disable iff (!resetn)
    state == SRF_WAIT && next_state == SRF_CONV |->
      pwrCnt == CNT_W'(POWERUP_CYC - 1))
    else $error("single shot delay wrong");
  a_sleep_idle: assert property (@(posedge clk) disable iff (!resetn)
    state == SRF_IDLE && modeAct == `SRF_MODE_SLEEP |=> state == SRF_IDLE)
    else $error("sampling started while asleep");
  a_pin_snap: assert property (@(posedge clk) disable iff (!resetn)
    pinRise && !noRise && !alarmAct && !snapType |-> snapFull)
    else $error("pin edge did not issue full snapshot");
  a_limited_snap: assert property (@(posedge clk) disable iff (!resetn)
    pinSnap && !hostSnap |=> $stable(ctrlAct) && $stable(fmtAct))
    else $error("pin snapshot applied pending config");
  a_full_clear: assert property (@(posedge clk) disable iff (!resetn)
    snapFull |=> accCount <= 32'h00000001)
    else $error("full snapshot left count uncleared");
  a_keep_acc: assert property (@(posedge clk) disable iff (!resetn)
    snapAny && !snapFull && !sampleTake |=> acc == $past(acc))
    else $error("keep snapshot disturbed accumulator");
  a_copy_read: assert property (@(posedge clk) disable iff (!resetn)
    snapAny |=> readBus[0] == $past(doneBus[0]) && readCount ==
      $past(accCount))
    else $error("snapshot did not copy results");
  a_mux_step: assert property (@(posedge clk) disable iff (!resetn)
    sampleTake && !lastCh |=> muxChannel == $past(muxChannel) + 2'h1
      && convStart)
    else $error("mux did not step to next channel");
endmodule

// >>> srf_adc_model.sv
`timescale 1ns/1ns
module srf_adc_model (
  input wire logic clk,
  input wire logic convStart,
  input wire logic [16:0] busVal,
  input wire logic [16:0] senseVal,
  output logic adcDone,
  output logic [16:0] adcBusRaw,
  output logic [16:0] adcSenseRaw
);
  integer seed = 32'h3E5DF9EF;
  integer waitLeft = 0;
  initial begin
    adcDone = 1'b0;
    adcBusRaw = 17'h00000;
    adcSenseRaw = 17'h00000;
  end
  // conversion time varies 1..4 cycles; data lines churn when not valid
  always @(posedge clk) begin
    adcDone <= 1'b0;
    adcBusRaw <= ~adcBusRaw;
    adcSenseRaw <= ~adcSenseRaw;
    if (convStart) begin
      waitLeft <= 1 + ($unsigned($random(seed)) % 4);
    end else if (waitLeft != 0) begin
      waitLeft <= waitLeft - 1;
      if (waitLeft == 1) begin
        adcDone <= 1'b1;
        adcBusRaw <= busVal;
        adcSenseRaw <= senseVal;
      end
    end
  end
endmodule

// >>> slow_rate_and_result_format_bench.sv
`timescale 1ns/1ns
module slow_rate_and_result_format_bench;
  localparam int PU = 20;
  localparam int C1K = 40;
  localparam int C8 = 100;
  logic clk = 1'b0;
  logic resetn, awvalid, wvalid, bready, arvalid, rready, ratePin, alarmCond;
  logic awready, wready, bvalid, arready, rvalid;
  logic ratePinOut, ratePinOe, convStart, adcDone, b, h;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, muxChannel;
  logic [16:0] busVal, senseVal, adcBusRaw, adcSenseRaw;
  integer badCount = 0;
  integer checked = 0;
  integer seed = 32'h3E5DF9EF;
  integer n;
  always #20 clk = ~clk;
  srf_monitor #(.POWERUP_CYC(20), .CYC_1024(40), .CYC_256(60),
    .CYC_64(80), .CYC_8(100)) srf_monitor_inst (.clk(clk), .resetn(resetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .ratePinIn(ratePinOe ? 1'b0 : ratePin),
    .ratePinOut(ratePinOut), .ratePinOe(ratePinOe), .alarmCond(alarmCond),
    .muxChannel(muxChannel), .convStart(convStart), .adcDone(adcDone),
    .adcBusRaw(adcBusRaw), .adcSenseRaw(adcSenseRaw));
  srf_adc_model srf_adc_model_inst (.clk(clk), .convStart(convStart),
    .busVal(busVal), .senseVal(senseVal), .adcDone(adcDone),
    .adcBusRaw(adcBusRaw), .adcSenseRaw(adcSenseRaw));
  task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      badCount++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    integer k;
    k = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      k++;
    end while (bvalid !== 1'b1 && k < 100);
    chk("bresp", {30'h0, bresp}, 32'h0);
    chk("bvalid", {31'h0, bvalid}, 32'h1);
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdr(input logic [7:0] a, input logic [1:0] er);
    integer k;
    k = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      k++;
    end while (rvalid !== 1'b1 && k < 100);
    rd = rdata;
    chk("rvalid", {31'h0, rvalid}, 32'h1);
    chk("rresp", {30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // cycles from one channel-0 start to the next
  task automatic per(output integer p);
    integer k;
    logic [1:0] last;
    k = 0;
    do @(posedge clk); while (!(convStart && muxChannel == 2'h0) && k++ < 500);
    p = 0;
    last = 2'h0;
    do begin
      @(posedge clk);
      p++;
      if (convStart && muxChannel != 2'h0) begin
        chk("channel", {30'h0, muxChannel}, {30'h0, last + 2'h1});
        last = muxChannel;
      end
    end while (!(convStart && muxChannel == 2'h0) && p < 500);
  endtask
  // first period may be the old rate, so judge the second
  task automatic rate(input integer exp, input string nm);
    integer p;
    per(p);
    per(p);
    chk(nm, p, exp);
  endtask
  function automatic logic [31:0] fx(input logic [16:0] r, input logic bp,
      input logic hf);
    if (!bp) return r[16] ? 32'h0 : {16'h0, r[15:0]};
    if (!hf) return {16'h0, r[16:1]};
    if (r[16] != r[15]) return r[16] ? 32'h8000 : 32'h7FFF;
    return {16'h0, r[15:0]};
  endfunction
  // product of top 14 bus bits and sense, sign kept when bipolar
  function automatic logic [31:0] pw(input logic [16:0] v,
      input logic [16:0] s, input logic bp, input logic hf);
    logic [15:0] fb;
    logic [15:0] fs;
    logic signed [14:0] t;
    logic signed [16:0] e;
    fb = 16'(fx(v, bp, hf));
    fs = 16'(fx(s, bp, hf));
    t = {bp && fb[15], fb[15:2]};
    e = {bp && fs[15], fs};
    return 32'(t * e);
  endfunction
  initial begin
    repeat (60000) @(posedge clk);
    badCount++;
    final_report();
  end
  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {ratePin, alarmCond} = 2'h0;
    {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hF};
    {busVal, senseVal} = 34'h0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rdr(8'h00, 2'h0);
    chk("ctrl reset", rd, 32'h0);
    rdr(8'h08, 2'h0);
    chk("pin reset", rd, 32'h0);
    rdr(8'hFC, 2'h2);
    chk("unmapped", rd, 32'h0);
    rate(C1K, "fast rate");
    ratePin <= 1'b1;
    rate(C8, "slow rate");
    rdr(8'h08, 2'h0);
    chk("pin level seen", {30'h0, rd[4:3]}, 32'h3);
    wr(8'h08, 32'h10);
    rdr(8'h08, 2'h0);
    chk("rise clear", {31'h0, rd[4]}, 32'h0);
    wr(8'h00, 32'h1);
    ratePin <= 1'b0;
    rate(C1K, "pending kept");
    ratePin <= 1'b1;
    repeat (10) @(posedge clk);
    wr(8'h0C, 32'h2);
    rdr(8'h48, 2'h0);
    chk("count cleared", {31'h0, rd <= 1}, 32'h1);
    wr(8'h08, 32'h1);
    repeat (300) @(posedge clk);
    ratePin <= 1'b0;
    repeat (10) @(posedge clk);
    wr(8'h0C, 32'h2);
    rdr(8'h48, 2'h0);
    chk("count kept", {31'h0, rd >= 2}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      b = i[0];
      h = i[1];
      busVal <= (i == 3) ? 17'h0A000 : 17'($random(seed));
      senseVal <= (i == 0) ? 17'h1F000 : 17'($random(seed));
      wr(8'h04, {16'h0, {4{h, b, h, b}}});
      wr(8'h0C, 32'h1);
      repeat (300) @(posedge clk);
      wr(8'h0C, 32'h2);
      rdr(8'h10, 2'h0);
      chk("bus", {16'h0, rd[15:0]}, fx(busVal, b, h));
      rdr(8'h20, 2'h0);
      chk("sense", {16'h0, rd[15:0]}, fx(senseVal, b, h));
      rdr(8'h30, 2'h0);
      chk("power", rd, pw(busVal, senseVal, b, h));
    end
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h10);
    wr(8'h0C, 32'h2);
    ratePin <= 1'b1;
    rate(C1K, "alarm role rate");
    alarmCond <= 1'b1;
    repeat (3) @(posedge clk);
    chk("alarm drive", {30'h0, ratePinOe, ratePinOut}, 32'h2);
    alarmCond <= 1'b0;
    wr(8'h00, 32'h13);
    wr(8'h0C, 32'h2);
    rate(C8, "alarm slow");
    ratePin <= 1'b0;
    wr(8'h00, 32'h04);
    wr(8'h0C, 32'h2);
    repeat (200) @(posedge clk);
    ratePin <= 1'b1;
    n = 0;
    do @(posedge clk); while (!convStart && n++ < 200);
    chk("powerup wait", {31'h0, n >= PU && n <= PU + 8}, 32'h1);
    ratePin <= 1'b0;
    wr(8'h00, 32'h08);
    wr(8'h0C, 32'h2);
    repeat (200) @(posedge clk);
    ratePin <= 1'b1;
    n = 0;
    repeat (150) begin
      @(posedge clk);
      if (convStart) n++;
    end
    chk("sleep", n, 32'h0);
    final_report();
  end
endmodule
